// [inc/accel_trim_pkg.sv]
// Package with register map, field layout and scaling constants of the accelerometer trim bank.
package accel_trim_pkg;
  localparam int unsigned ADDR_W         = 7;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned TRIM_W         = 15;
  localparam int unsigned SAMPLE_W       = 16;
  localparam int unsigned AXES           = 3;
  localparam logic [6:0]  ACCEL_X_TRIM_HIGH = 7'h77;
  localparam logic [6:0]  ACCEL_X_TRIM_LOW  = 7'h78;
  localparam logic [6:0]  ACCEL_Y_TRIM_HIGH = 7'h7a;
  localparam logic [6:0]  ACCEL_Y_TRIM_LOW  = 7'h7b;
  localparam logic [6:0]  ACCEL_Z_TRIM_HIGH = 7'h7d;
  localparam logic [6:0]  ACCEL_Z_TRIM_LOW  = 7'h7e;
  localparam int unsigned HIGH_FIELD_LSB = 7;
  localparam int unsigned LOW_FIELD_LSB  = 1;
  localparam int unsigned LOW_FIELD_W    = 7;
  localparam logic [7:0]  TRIM_BYTE_RST  = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;
  // Scaling: one trim step is 0.98 mg, span +/-16 g, independent of full scale.
  localparam real         TRIM_STEP_MG   = 0.98;
  localparam int unsigned TRIM_SPAN_G    = 16;
  localparam int unsigned FS_SHIFT_W     = 2;
  // One trim step equals 2^(TRIM_SHIFT_FS0 - code) sample steps for full-scale code 0..3 (2 g .. 16 g).
  localparam int unsigned TRIM_SHIFT_FS0 = 4;
endpackage

// [src/trim_adder.sv]
// Saturating adder that applies one axis's signed trim to one accelerometer sample.
`timescale 1ns/10ps
module trim_adder
  import accel_trim_pkg::*;
(
  input  wire logic [1:0]          fs_sel_i,
  input  wire logic [TRIM_W-1:0]   trim_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  output logic      [SAMPLE_W-1:0] sum_o
);
  logic signed [SAMPLE_W+4:0] trim_ext;
  logic signed [SAMPLE_W+4:0] acc;
  logic        [2:0]          shamt;

  // The trim step is fixed in g while the sample step grows with the range, so the trim is
  // shifted by fewer places as the range widens. The sum saturates rather than wraps.
  always_comb begin
    shamt    = 3'(TRIM_SHIFT_FS0) - {1'b0, fs_sel_i};
    trim_ext = (SAMPLE_W+5)'(signed'(trim_i)) <<< shamt;
    acc      = (SAMPLE_W+5)'(signed'(sample_i)) + trim_ext;
    if (acc > (SAMPLE_W+5)'(32767)) begin
      sum_o = 16'h7fff;
    end else if (acc < -(SAMPLE_W+5)'(32768)) begin
      sum_o = 16'h8000;
    end else begin
      sum_o = acc[SAMPLE_W-1:0];
    end
  end
endmodule

// [src/accel_offset_trim_registers.sv]
// Accelerometer offset trim register bank with per-axis trim application to samples.
//
// Overview of operation
// RULE1: High trim register holds trim bits 14..7 in all eight bits.
// RULE2: Low trim register holds trim bits 6..0 in bits 7..1; bit 0 reserved.
// RULE3: Each trim is 15 bits wide, one step equals 0.98 mg.
// RULE4: Trim spans +/-16 g with equal scaling in every full-scale range.
// RULE5: X low trim register is read/write at address 0x78.
// RULE6: Y high and low trim registers are read/write at 0x7A and 0x7B.
// RULE7: Z high and low trim registers are read/write at 0x7D and 0x7E.
// RULE8: X high trim register is read/write at address 0x77.
// RULE9: Trim is two's complement and added to samples before the data registers.
`timescale 1ns/10ps
module accel_offset_trim_registers
  import accel_trim_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [ADDR_W-1:0]     reg_addr_i,
  input  wire logic [DATA_W-1:0]     reg_wdata_i,
  input  wire logic [1:0]            accel_fs_sel_i,
  input  wire logic                  sample_valid_i,
  input  wire logic [3*SAMPLE_W-1:0] sample_raw_i,
  output logic      [DATA_W-1:0]     reg_rdata_o,
  output logic                       reg_hit_o,
  output logic                       data_valid_o,
  output logic      [3*SAMPLE_W-1:0] data_trimmed_o,
  output logic      [TRIM_W-1:0]     x_axis_trim_value_o,
  output logic      [TRIM_W-1:0]     y_axis_trim_value_o,
  output logic      [TRIM_W-1:0]     z_axis_trim_value_o
);
  // Per-axis trim state.
  logic [TRIM_W-1:0]     trim_ff     [AXES];
  logic [TRIM_W-1:0]     nxt_trim    [AXES];
  // Register port state.
  logic [DATA_W-1:0]     rdata_ff;
  logic [DATA_W-1:0]     nxt_rdata;
  logic                  hit_ff;
  logic                  nxt_hit;
  // Sample path state.
  logic                  valid_ff;
  logic                  nxt_valid;
  logic [3*SAMPLE_W-1:0] data_ff;
  logic [3*SAMPLE_W-1:0] nxt_data;
  logic [3*SAMPLE_W-1:0] sum_all;
  // Address decode.
  logic [AXES-1:0]       sel_high;
  logic [AXES-1:0]       sel_low;
  logic [AXES-1:0]       wr_high;
  logic [AXES-1:0]       wr_low;
  logic                  addr_mapped;
  logic [DATA_W-1:0]     high_byte   [AXES];
  logic [DATA_W-1:0]     low_byte    [AXES];

  // The decode is one case so that no two registers can ever answer the same address.
  always_comb begin
    sel_high    = '0;
    sel_low     = '0;
    addr_mapped = 1'b0;
    case (reg_addr_i)
      ACCEL_X_TRIM_HIGH: begin
        sel_high[0] = 1'b1; // RULE8
        addr_mapped = 1'b1;
      end
      ACCEL_X_TRIM_LOW: begin
        sel_low[0]  = 1'b1; // RULE5
        addr_mapped = 1'b1;
      end
      ACCEL_Y_TRIM_HIGH: begin
        sel_high[1] = 1'b1; // RULE6
        addr_mapped = 1'b1;
      end
      ACCEL_Y_TRIM_LOW: begin
        sel_low[1]  = 1'b1; // RULE6
        addr_mapped = 1'b1;
      end
      ACCEL_Z_TRIM_HIGH: begin
        sel_high[2] = 1'b1; // RULE7
        addr_mapped = 1'b1;
      end
      ACCEL_Z_TRIM_LOW: begin
        sel_low[2]  = 1'b1; // RULE7
        addr_mapped = 1'b1;
      end
      default: begin
        sel_high    = '0;
        sel_low     = '0;
        addr_mapped = 1'b0;
      end
    endcase
  end

  // Writes to unmapped addresses fall through the decode and change nothing.
  assign wr_high = sel_high & {AXES{reg_wr_i}};
  assign wr_low  = sel_low & {AXES{reg_wr_i}};

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      // The two bytes are written independently with no shadow copy, so a host that updates
      // a trim in two writes applies a mixed value for the samples taken in between.
      always_comb begin
        nxt_trim[g] = trim_ff[g];
        if (wr_high[g]) begin
          nxt_trim[g][TRIM_W-1:HIGH_FIELD_LSB] = reg_wdata_i; // RULE1
        end
        if (wr_low[g]) begin
          // The reserved bit 0 of the written byte is dropped.
          nxt_trim[g][LOW_FIELD_W-1:0] = reg_wdata_i[DATA_W-1:LOW_FIELD_LSB]; // RULE2
        end
      end

      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          trim_ff[g] <= {TRIM_BYTE_RST[TRIM_W-DATA_W-1:0], TRIM_BYTE_RST}; // RULE3
        end else begin
          trim_ff[g] <= nxt_trim[g];
        end
      end

      // Byte views for the read path; the reserved bit always reads as zero.
      assign high_byte[g] = trim_ff[g][TRIM_W-1:HIGH_FIELD_LSB]; // RULE1
      assign low_byte[g]  = {trim_ff[g][LOW_FIELD_W-1:0], 1'b0}; // RULE2

      trim_adder u_trim_adder (
        .fs_sel_i (accel_fs_sel_i),                            // RULE4
        .trim_i   (trim_ff[g]),                                // RULE9
        .sample_i (sample_raw_i[g*SAMPLE_W +: SAMPLE_W]),
        .sum_o    (sum_all[g*SAMPLE_W +: SAMPLE_W])
      );
    end
  endgenerate

  // Read data is registered, so it appears one cycle after the read strobe and then holds.
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_hit   = 1'b0;
    if (reg_rd_i) begin
      nxt_hit = addr_mapped;
      case (reg_addr_i)
        ACCEL_X_TRIM_HIGH: begin
          nxt_rdata = high_byte[0]; // RULE8
        end
        ACCEL_X_TRIM_LOW: begin
          nxt_rdata = low_byte[0]; // RULE5
        end
        ACCEL_Y_TRIM_HIGH: begin
          nxt_rdata = high_byte[1]; // RULE6
        end
        ACCEL_Y_TRIM_LOW: begin
          nxt_rdata = low_byte[1]; // RULE6
        end
        ACCEL_Z_TRIM_HIGH: begin
          nxt_rdata = high_byte[2]; // RULE7
        end
        ACCEL_Z_TRIM_LOW: begin
          nxt_rdata = low_byte[2]; // RULE7
        end
        default: begin
          nxt_rdata = UNMAPPED_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= TRIM_BYTE_RST;
      hit_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      hit_ff   <= nxt_hit;
    end
  end

  // A sample is taken only with its strobe, so the trimmed output holds between samples.
  always_comb begin
    nxt_valid = sample_valid_i;
    nxt_data  = data_ff;
    if (sample_valid_i) begin
      nxt_data = sum_all; // RULE9
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_ff <= '0;
    end else begin
      data_ff <= nxt_data;
    end
  end

  assign reg_rdata_o         = rdata_ff;
  assign reg_hit_o           = hit_ff;
  assign data_valid_o        = valid_ff;
  assign data_trimmed_o      = data_ff;
  assign x_axis_trim_value_o = trim_ff[0];
  assign y_axis_trim_value_o = trim_ff[1];
  assign z_axis_trim_value_o = trim_ff[2];
endmodule

// [tb/host_model.sv]
// Host model issuing single register cycles.
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk_i,
  output logic            wr_o = 0,
  output logic            rd_o = 0,
  output logic [6:0]      addr_o = 0,
  output logic [7:0]      wdata_o = 0
);
  // A released bus shows inverted values so stale data cannot pass for a match.
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i) #1 {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
    @(posedge clk_i) #1 {wr_o, rd_o, addr_o, wdata_o} = {2'b0, ~a, ~d};
  endtask
endmodule

// [tb/trim_monitor.sv]
// Checker of the trim bank register port.
`timescale 1ns/10ps
module trim_monitor (
  input wire logic        clk_i, rst_i, reg_wr_i, reg_rd_i, reg_hit_o,
  input wire logic [6:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i, reg_rdata_o,
  input wire logic [14:0] x_axis_trim_value_o, y_axis_trim_value_o, z_axis_trim_value_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_XH: assert property (reg_wr_i && reg_addr_i == 7'h77
    |=> x_axis_trim_value_o[14:7] == $past(reg_wdata_i)) else $error("x high");
  AST_XL: assert property (reg_wr_i && reg_addr_i == 7'h78
    |=> x_axis_trim_value_o[6:0] == $past(reg_wdata_i) >> 1) else $error("x low");
  AST_YH: assert property (reg_wr_i && reg_addr_i == 7'h7a
    |=> y_axis_trim_value_o[14:7] == $past(reg_wdata_i)) else $error("y high");
  AST_YL: assert property (reg_wr_i && reg_addr_i == 7'h7b
    |=> y_axis_trim_value_o[6:0] == $past(reg_wdata_i) >> 1) else $error("y low");
  AST_ZH: assert property (reg_wr_i && reg_addr_i == 7'h7d
    |=> z_axis_trim_value_o[14:7] == $past(reg_wdata_i)) else $error("z high");
  AST_ZL: assert property (reg_wr_i && reg_addr_i == 7'h7e
    |=> z_axis_trim_value_o[6:0] == $past(reg_wdata_i) >> 1) else $error("z low");
  AST_HIT: assert property (reg_rd_i
    |=> reg_hit_o == ($past(reg_addr_i) inside {7'h77, 7'h78, 7'h7a, 7'h7b, 7'h7d, 7'h7e})) else $error("hit");
  AST_RD0: assert property (reg_rd_i && reg_addr_i inside {7'h78, 7'h7b, 7'h7e}
    |=> !reg_rdata_o[0]) else $error("reserved bit");
endmodule
bind accel_offset_trim_registers trim_monitor i_mon (.*);

// [tb/accel_offset_trim_registers_tb.sv]
// Bench for the trim register bank.
`timescale 1ns/10ps
module accel_offset_trim_registers_tb;
  import accel_trim_pkg::*;
  logic clk_i = 0, rst_i = 1, reg_wr_i, reg_rd_i, sample_valid_i = 0, reg_hit_o, data_valid_o, rd_d = 0;
  logic [1:0] accel_fs_sel_i = 0;
  logic [6:0] reg_addr_i, amap[6] = '{7'h77, 7'h78, 7'h7a, 7'h7b, 7'h7d, 7'h7e};
  logic [7:0] reg_wdata_i, reg_rdata_o, hi, lo;
  logic [8:0] exp_q[$];
  logic [14:0] x_axis_trim_value_o, y_axis_trim_value_o, z_axis_trim_value_o, tv[3], exp_t[3];
  logic [47:0] sample_raw_i = 0, data_trimmed_o;
  int n_fail = 0, checked = 0, seed = 9, cyc = 0;
  accel_offset_trim_registers i_dut (.*);
  host_model i_host (.clk_i, .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  assign tv = '{x_axis_trim_value_o, y_axis_trim_value_o, z_axis_trim_value_o};
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [16:0] e, s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  // Expected trimmed sample: one trim step is 2^(shift - code) sample steps, saturating.
  function automatic logic [15:0] trimmed(input logic [15:0] raw, input logic [14:0] t, input int f);
    int v;
    v = $signed(raw) + $signed(t) * (1 << (TRIM_SHIFT_FS0 - f));
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction
  task automatic rdx(input logic [6:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    i_host.access(0, a, 0);
  endtask
  task automatic finish_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read results settle at the edge after the strobe; they are looked at half a period later.
  always @(negedge clk_i) begin
    if (rd_d) chk("read", exp_q.pop_front(), {reg_hit_o, reg_rdata_o});
  end
  always @(posedge clk_i) begin
    rd_d <= reg_rd_i;
    if (++cyc > 2000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    #1 rst_i = 0;
    foreach (amap[i]) rdx(amap[i], 9'h100);
    for (int k = 0; k < 3; k++) begin
      hi = $random(seed);
      lo = $random(seed);
      i_host.access(1, amap[2*k], hi);
      i_host.access(1, amap[2*k+1], lo);
      exp_t[k] = {hi, lo[7:1]};
      chk("trim", {hi, lo[7:1]}, tv[k]);
      rdx(amap[2*k], {1'b1, hi});
      rdx(amap[2*k+1], {1'b1, lo[7:1], 1'b0});
    end
    i_host.access(1, 7'h7c, 8'hff);
    chk("keep", {hi, lo[7:1]}, tv[2]);
    rdx(7'h79, 9'h000);
    $display("register test done");
    i_host.access(1, 7'h77, 8'hff);
    i_host.access(1, 7'h78, 8'hfa);
    exp_t[0] = 15'h7ffd;
    for (int f = 0; f < 4; f++) begin
      @(posedge clk_i) #1 begin
        accel_fs_sel_i = f[1:0];
        sample_raw_i   = {16'h0100, 32'($random(seed))};
        sample_raw_i[15:0] = 16'h0100;
        sample_valid_i = 1;
      end
      @(posedge clk_i) #1 sample_valid_i = 0;
      chk("sample", {1'b1, 16'h0100 - (16'h0003 << (TRIM_SHIFT_FS0 - f))},
          {data_valid_o, data_trimmed_o[15:0]});
      for (int a = 1; a < 3; a++) begin
        chk("lane", trimmed(sample_raw_i[16*a +: 16], exp_t[a], f), data_trimmed_o[16*a +: 16]);
      end
    end
    $display("sample test done");
    finish_test();
  end
endmodule
